//--- inc/fault_defs.svh
`ifndef FAULT_DEFS_SVH
`define FAULT_DEFS_SVH
// Overview of operation
// RULE1: No-execute fetch raises a fault.
// RULE2: Vector read bus error takes hard fault, sets vector flag.
// RULE3: Escalation takes hard fault and sets escalation flag.
// RULE4: Instruction mismatch sets instruction flag; no-execute even with protection off.
// RULE5: Data mismatch raises memory management fault with data flag.
// RULE6: Stacking mismatch sets push flag; unstacking sets pop flag.
// RULE7: Stacking bus error sets bus push flag; unstacking sets bus pop flag.
// RULE8: Prefetch bus error raises bus fault with instruction flag.
// RULE9: Data bus error sets exact flag if attributable, else inexact.
// RULE10: Coprocessor access and undefined opcode raise usage faults with flags.
// RULE11: Foreign instruction set or bad continuation sets invalid-state flag.
// RULE12: Invalid exception-return value sets invalid-return flag.
// RULE13: Unaligned access and zero divide raise usage faults with flags.
// RULE14: Configurable classes have programmable priority and separate handler enables.
// RULE15: Handler raising its own fault kind escalates.
// RULE16: Fault handler raising equal or lower priority fault escalates.
// RULE17: Any handler raising equal or lower priority fault, or disabled handler, escalates.
// RULE18: Bus fault on push entering bus fault handler is not escalated.
// RULE19: Hard fault has fixed priority; preempts all but reset, NMI, hard fault.
// RULE20: Bus and memory management faults capture faulting address.
// RULE21: Hard fault in NMI or hard fault handler enters lockup.
// RULE22: Lockup ends on reset, NMI or debug halt; NMI-origin lockup ignores NMI.
// RULE23: Every status flag stays set until software clears it.

`define HARD_FLAG_W 2
`define HARD_VECTOR_BIT 0
`define HARD_ESCALATION_BIT 1

`define MM_FLAG_W 4
`define MM_INSTR_BIT 0
`define MM_DATA_BIT 1
`define MM_PUSH_BIT 2
`define MM_POP_BIT 3

`define BUS_FLAG_W 5
`define BUS_INSTR_BIT 0
`define BUS_EXACT_BIT 1
`define BUS_INEXACT_BIT 2
`define BUS_POP_BIT 3
`define BUS_PUSH_BIT 4

`define USAGE_FLAG_W 6
`define USAGE_BAD_OPCODE_BIT 0
`define USAGE_INV_STATE_BIT 1
`define USAGE_INV_RETURN_BIT 2
`define USAGE_NO_COPROC_BIT 3
`define USAGE_MISALIGN_BIT 4
`define USAGE_ZERO_DIV_BIT 5

`define HANDLER_MM_BIT 0
`define HANDLER_BUS_BIT 1
`define HANDLER_USAGE_BIT 2
`define HANDLER_W 3

`define ADDR_W 32
`define ADDR_RESET 32'h0000_0000
`define PRIORITY_W 3
`endif

//--- inc/fault_pkg.sv
package fault_pkg;

    typedef enum logic [2:0] {
        KIND_NONE  = 3'b000,
        KIND_HARD  = 3'b001,
        KIND_MEM   = 3'b010,
        KIND_BUS   = 3'b011,
        KIND_USAGE = 3'b100,
        KIND_NMI   = 3'b101,
        KIND_OTHER = 3'b110
    } exc_kind_e;

    typedef enum logic [1:0] {
        RUNNING     = 2'b00,
        LOCKED_HARD = 2'b01,
        LOCKED_NMI  = 2'b10
    } lock_state_e;

    // Error reports from the far side
    typedef struct packed {
        logic xn_fetch;
        logic instr_mismatch;
        logic data_mismatch;
        logic push_mismatch;
        logic pop_mismatch;
        logic vector_bus_error;
        logic push_bus_error;
        logic pop_bus_error;
        logic prefetch_bus_error;
        logic data_bus_error;
        logic data_bus_exact;
        logic coproc_access;
        logic bad_opcode;
        logic foreign_isa;
        logic bad_continuation;
        logic invalid_return;
        logic misaligned;
        logic zero_divide;
    } fault_report_s;

    // Core context beside each report
    typedef struct packed {
        logic in_handler;
        exc_kind_e active_kind;
        logic bus_handler_entry;
    } exec_context_s;

endpackage

//--- logic/sticky_flags.sv
`timescale 1ns/100ps
`include "fault_defs.svh"

module sticky_flags #(
    parameter int WIDTH = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clear,
    output logic [WIDTH-1:0] flags
);

    initial
    begin
        if (WIDTH < 1)
        begin
            $error("WIDTH must be at least 1");
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags <= '0;
        end
        else
        begin
            flags <= (flags & ~clear) | set; // see RULE23
        end
    end

endmodule // sticky_flags

//--- logic/cpu_fault_handling_unit.sv
`timescale 1ns/100ps
`include "fault_defs.svh"

module cpu_fault_handling_unit #(
    parameter int PRIO_W = `PRIORITY_W
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire fault_pkg::fault_report_s report,
    input wire logic [`ADDR_W-1:0] access_addr,
    input wire logic [`ADDR_W-1:0] data_addr,
    input wire fault_pkg::exec_context_s context_in,
    input wire logic [PRIO_W-1:0] current_priority,
    input wire logic [PRIO_W-1:0] mm_priority,
    input wire logic [PRIO_W-1:0] bus_priority,
    input wire logic [PRIO_W-1:0] usage_priority,
    input wire logic [`HANDLER_W-1:0] handler_enable_reg,
    input wire logic nmi_request,
    input wire logic debug_halt,
    input wire logic [`HARD_FLAG_W-1:0] hard_clear,
    input wire logic [`MM_FLAG_W-1:0] mm_clear,
    input wire logic [`BUS_FLAG_W-1:0] bus_clear,
    input wire logic [`USAGE_FLAG_W-1:0] usage_clear,
    input wire logic mm_addr_clear,
    input wire logic bus_addr_clear,
    output logic [`HARD_FLAG_W-1:0] hard_fault_cause_reg,
    output logic [`MM_FLAG_W-1:0] memmanage_fault_cause_reg,
    output logic [`BUS_FLAG_W-1:0] bus_fault_cause_reg,
    output logic [`USAGE_FLAG_W-1:0] usage_fault_cause_reg,
    output logic [`ADDR_W-1:0] memmanage_fault_address,
    output logic memmanage_address_valid,
    output logic [`ADDR_W-1:0] bus_fault_address,
    output logic bus_address_valid,
    output logic fault_taken,
    output fault_pkg::exc_kind_e fault_handler,
    output logic [PRIO_W-1:0] fault_priority,
    output logic hard_priority_fixed,
    output logic hard_preempts,
    output logic escalated,
    output logic lockup,
    output logic lockup_from_nmi
);

    initial
    begin
        if (PRIO_W < 1 || PRIO_W > 8)
        begin
            $error("PRIO_W out of range");
        end
    end

    logic [1:0] rst_sync;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_sync <= 2'b00;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];

    fault_pkg::lock_state_e lock_state;
    fault_pkg::lock_state_e next_lock_state;
    logic running;

    assign running = (lock_state == fault_pkg::RUNNING);

    logic [`MM_FLAG_W-1:0] mm_set;
    logic [`BUS_FLAG_W-1:0] bus_set;
    logic [`USAGE_FLAG_W-1:0] usage_set;
    logic [`HARD_FLAG_W-1:0] hard_set;

    always_comb
    begin
        // No-execute fetch counts even with protection disabled
        mm_set[`MM_INSTR_BIT] = report.instr_mismatch | report.xn_fetch; // see RULE1 see RULE4
        mm_set[`MM_DATA_BIT] = report.data_mismatch; // see RULE5
        mm_set[`MM_PUSH_BIT] = report.push_mismatch; // see RULE6
        mm_set[`MM_POP_BIT] = report.pop_mismatch; // see RULE6
    end

    always_comb
    begin
        bus_set[`BUS_INSTR_BIT] = report.prefetch_bus_error; // see RULE8
        bus_set[`BUS_EXACT_BIT] = report.data_bus_error & report.data_bus_exact; // see RULE9
        bus_set[`BUS_INEXACT_BIT] = report.data_bus_error & ~report.data_bus_exact; // see RULE9
        bus_set[`BUS_PUSH_BIT] = report.push_bus_error; // see RULE7
        bus_set[`BUS_POP_BIT] = report.pop_bus_error; // see RULE7
    end

    always_comb
    begin
        usage_set[`USAGE_NO_COPROC_BIT] = report.coproc_access; // see RULE10
        usage_set[`USAGE_BAD_OPCODE_BIT] = report.bad_opcode; // see RULE10
        usage_set[`USAGE_INV_STATE_BIT] = report.foreign_isa | report.bad_continuation; // see RULE11
        usage_set[`USAGE_INV_RETURN_BIT] = report.invalid_return; // see RULE12
        usage_set[`USAGE_MISALIGN_BIT] = report.misaligned; // see RULE13
        usage_set[`USAGE_ZERO_DIV_BIT] = report.zero_divide; // see RULE13
    end

    logic mm_hit;
    logic bus_hit;
    logic usage_hit;
    logic vector_hit;

    assign mm_hit = |mm_set;
    assign bus_hit = |bus_set;
    assign usage_hit = |usage_set;
    assign vector_hit = report.vector_bus_error;

    function automatic logic must_escalate(
        input fault_pkg::exc_kind_e kind,
        input logic [PRIO_W-1:0] prio,
        input logic enabled
    );
        return !enabled || (context_in.in_handler && (context_in.active_kind == kind || prio >= current_priority));
    endfunction

    logic mm_escalate;
    logic bus_escalate;
    logic usage_escalate;
    logic bus_entry_push;

    // A push error that is the only bus flag while entering the bus handler is not escalated
    assign bus_entry_push = context_in.bus_handler_entry && report.push_bus_error
        && (bus_set == (`BUS_FLAG_W'(1) << `BUS_PUSH_BIT));

    always_comb
    begin
        mm_escalate = mm_hit && must_escalate(fault_pkg::KIND_MEM, mm_priority,
            handler_enable_reg[`HANDLER_MM_BIT]); // see RULE15 see RULE16 see RULE17
        bus_escalate = bus_hit && !bus_entry_push // see RULE18
            && must_escalate(fault_pkg::KIND_BUS, bus_priority,
            handler_enable_reg[`HANDLER_BUS_BIT]); // see RULE15 see RULE16 see RULE17
        usage_escalate = usage_hit && must_escalate(fault_pkg::KIND_USAGE, usage_priority,
            handler_enable_reg[`HANDLER_USAGE_BIT]); // see RULE15 see RULE16 see RULE17
    end

    logic any_escalate;
    logic take_hard;
    logic take_any;
    fault_pkg::exc_kind_e next_handler;
    logic [PRIO_W-1:0] next_priority;

    assign any_escalate = mm_escalate | bus_escalate | usage_escalate;
    assign take_hard = vector_hit | any_escalate; // see RULE2 see RULE3
    assign take_any = take_hard | mm_hit | bus_hit | usage_hit;

    always_comb
    begin
        next_handler = fault_pkg::KIND_NONE;
        next_priority = '0;
        if (take_hard)
        begin
            next_handler = fault_pkg::KIND_HARD;
        end
        else if (mm_hit)
        begin
            next_handler = fault_pkg::KIND_MEM;
            next_priority = mm_priority; // see RULE14
        end
        else if (bus_hit)
        begin
            next_handler = fault_pkg::KIND_BUS;
            next_priority = bus_priority; // see RULE14
        end
        else if (usage_hit)
        begin
            next_handler = fault_pkg::KIND_USAGE;
            next_priority = usage_priority; // see RULE14
        end
    end

    always_comb
    begin
        hard_set[`HARD_VECTOR_BIT] = vector_hit; // see RULE2
        hard_set[`HARD_ESCALATION_BIT] = any_escalate; // see RULE3
    end

    sticky_flags #(
        .WIDTH(`HARD_FLAG_W)
    ) hard_flags (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .set(hard_set),
        .clear(hard_clear),
        .flags(hard_fault_cause_reg)
    );

    sticky_flags #(
        .WIDTH(`MM_FLAG_W)
    ) mm_flags (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .set(mm_set),
        .clear(mm_clear),
        .flags(memmanage_fault_cause_reg)
    );

    sticky_flags #(
        .WIDTH(`BUS_FLAG_W)
    ) bus_flags (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .set(bus_set),
        .clear(bus_clear),
        .flags(bus_fault_cause_reg)
    );

    sticky_flags #(
        .WIDTH(`USAGE_FLAG_W)
    ) usage_flags (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .set(usage_set),
        .clear(usage_clear),
        .flags(usage_fault_cause_reg)
    );

    logic mm_addr_event;
    logic bus_addr_event;

    assign mm_addr_event = report.data_mismatch | report.instr_mismatch | report.xn_fetch;
    assign bus_addr_event = report.data_bus_error & report.data_bus_exact;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            memmanage_fault_address <= `ADDR_RESET;
            memmanage_address_valid <= 1'b0;
        end
        else if (mm_addr_event)
        begin
            memmanage_fault_address <= report.data_mismatch ? data_addr : access_addr; // see RULE20
            memmanage_address_valid <= 1'b1;
        end
        else if (mm_addr_clear)
        begin
            memmanage_address_valid <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_fault_address <= `ADDR_RESET;
            bus_address_valid <= 1'b0;
        end
        else if (bus_addr_event)
        begin
            bus_fault_address <= data_addr; // see RULE20
            bus_address_valid <= 1'b1;
        end
        else if (bus_addr_clear)
        begin
            bus_address_valid <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fault_taken <= 1'b0;
            fault_handler <= fault_pkg::KIND_NONE;
            fault_priority <= '0;
            hard_priority_fixed <= 1'b0;
            hard_preempts <= 1'b0;
            escalated <= 1'b0;
        end
        else
        begin
            fault_taken <= running && take_any;
            fault_handler <= running ? next_handler : fault_pkg::KIND_NONE;
            fault_priority <= running ? next_priority : '0;
            hard_priority_fixed <= running && take_hard; // see RULE19
            hard_preempts <= running && take_hard
                && context_in.active_kind != fault_pkg::KIND_NMI
                && context_in.active_kind != fault_pkg::KIND_HARD; // see RULE19
            escalated <= running && any_escalate; // see RULE3
        end
    end

    always_comb
    begin
        next_lock_state = lock_state;
        case (lock_state)
            fault_pkg::RUNNING:
            begin
                if (take_hard && context_in.active_kind == fault_pkg::KIND_NMI)
                begin
                    next_lock_state = fault_pkg::LOCKED_NMI; // see RULE21
                end
                else if (take_hard && context_in.active_kind == fault_pkg::KIND_HARD)
                begin
                    next_lock_state = fault_pkg::LOCKED_HARD; // see RULE21
                end
            end
            fault_pkg::LOCKED_HARD:
            begin
                if (nmi_request || debug_halt)
                begin
                    next_lock_state = fault_pkg::RUNNING; // see RULE22
                end
            end
            fault_pkg::LOCKED_NMI:
            begin
                if (debug_halt)
                begin
                    next_lock_state = fault_pkg::RUNNING; // see RULE22
                end
            end
            default:
            begin
                next_lock_state = fault_pkg::RUNNING;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lock_state <= fault_pkg::RUNNING; // see RULE22
        end
        else
        begin
            lock_state <= next_lock_state;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lockup <= 1'b0;
            lockup_from_nmi <= 1'b0;
        end
        else
        begin
            lockup <= (next_lock_state != fault_pkg::RUNNING);
            lockup_from_nmi <= (next_lock_state == fault_pkg::LOCKED_NMI);
        end
    end

endmodule // cpu_fault_handling_unit

//--- tb/fault_source.sv
`timescale 1ns/100ps

module fault_source (
    input wire logic sys_clk,
    input wire logic cmd_valid,
    input wire logic [17:0] cmd_bits,
    input wire logic [31:0] cmd_addr,
    output fault_pkg::fault_report_s report,
    output logic [31:0] access_addr,
    output logic [31:0] data_addr
);
    initial
    begin
        report = '0;
        access_addr = 32'h0;
        data_addr = 32'hFFFF_FFFF;
    end

    always @(posedge sys_clk)
    begin
        report <= cmd_valid ? fault_pkg::fault_report_s'(cmd_bits) : '0;
        access_addr <= cmd_valid ? cmd_addr : ~access_addr;
        data_addr <= cmd_valid ? {cmd_addr[15:0], cmd_addr[31:16]} : ~data_addr;
    end
endmodule // fault_source

//--- tb/cpu_fault_handling_unit_sva.sv
`timescale 1ns/100ps
`include "fault_defs.svh"

module fault_checker #(
    parameter int PRIO_W = `PRIORITY_W
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input fault_pkg::fault_report_s report,
    input wire logic [`ADDR_W-1:0] access_addr,
    input wire logic [`ADDR_W-1:0] data_addr,
    input fault_pkg::exec_context_s context_in,
    input wire logic [PRIO_W-1:0] usage_priority,
    input wire logic [`HANDLER_W-1:0] handler_enable_reg,
    input wire logic nmi_request,
    input wire logic debug_halt,
    input wire logic [`HARD_FLAG_W-1:0] hard_fault_cause_reg,
    input wire logic [`MM_FLAG_W-1:0] memmanage_fault_cause_reg,
    input wire logic [`BUS_FLAG_W-1:0] bus_fault_cause_reg,
    input wire logic [`ADDR_W-1:0] memmanage_fault_address,
    input wire logic [`ADDR_W-1:0] bus_fault_address,
    input fault_pkg::exc_kind_e fault_handler,
    input wire logic [PRIO_W-1:0] fault_priority,
    input wire logic hard_priority_fixed,
    input wire logic hard_preempts,
    input wire logic escalated,
    input wire logic lockup,
    input wire logic lockup_from_nmi
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    property p_vector;
        report.vector_bus_error && !lockup |=> hard_fault_cause_reg[`HARD_VECTOR_BIT] && fault_handler == fault_pkg::KIND_HARD;
    endproperty
    a_vector: assert property (p_vector) else $error("vector fault");
    property p_escalate;
        escalated |-> hard_fault_cause_reg[`HARD_ESCALATION_BIT] && fault_handler == fault_pkg::KIND_HARD && fault_priority == '0;
    endproperty
    a_escalate: assert property (p_escalate) else $error("escalation");
    property p_disabled;
        report.misaligned && !handler_enable_reg[`HANDLER_USAGE_BIT] && !lockup |=> escalated;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled handler");
    property p_instr;
        (report.xn_fetch || report.instr_mismatch) && !report.data_mismatch
            |=> memmanage_fault_cause_reg[`MM_INSTR_BIT] && memmanage_fault_address == $past(access_addr);
    endproperty
    a_instr: assert property (p_instr) else $error("instr fault");
    property p_data_mm;
        report.data_mismatch && !report.xn_fetch && !report.instr_mismatch
            |=> memmanage_fault_cause_reg[`MM_DATA_BIT] && memmanage_fault_address == $past(data_addr);
    endproperty
    a_data_mm: assert property (p_data_mm) else $error("data fault");
    property p_stack;
        report.push_mismatch || report.pop_mismatch
            |=> &(memmanage_fault_cause_reg[3:2] | ~$past({report.pop_mismatch, report.push_mismatch}));
    endproperty
    a_stack: assert property (p_stack) else $error("stacking flag");
    property p_data_bus;
        report.data_bus_error |=> ($past(report.data_bus_exact) ? bus_fault_cause_reg[`BUS_EXACT_BIT]
            && bus_fault_address == $past(data_addr) : bus_fault_cause_reg[`BUS_INEXACT_BIT]);
    endproperty
    a_data_bus: assert property (p_data_bus) else $error("data bus flag");
    property p_push_entry;
        report.push_bus_error && $countones(report) == 1 && context_in.bus_handler_entry
            && handler_enable_reg[`HANDLER_BUS_BIT] && !lockup |=> !escalated && fault_handler == fault_pkg::KIND_BUS;
    endproperty
    a_push_entry: assert property (p_push_entry) else $error("entry escalated");
    property p_prio;
        fault_handler == fault_pkg::KIND_USAGE |-> fault_priority == $past(usage_priority)
            && $past(handler_enable_reg[`HANDLER_USAGE_BIT]);
    endproperty
    a_prio: assert property (p_prio) else $error("usage priority");
    property p_preempt;
        hard_preempts |-> hard_priority_fixed && fault_handler == fault_pkg::KIND_HARD
            && $past(context_in.active_kind) != fault_pkg::KIND_NMI;
    endproperty
    a_preempt: assert property (p_preempt) else $error("preemption");
    property p_lock_nmi;
        fault_handler == fault_pkg::KIND_HARD && $past(context_in.active_kind) == fault_pkg::KIND_NMI
            |-> lockup && lockup_from_nmi;
    endproperty
    a_lock_nmi: assert property (p_lock_nmi) else $error("nmi lockup");
    property p_nmi_hold;
        lockup_from_nmi && nmi_request && !debug_halt |=> lockup;
    endproperty
    a_nmi_hold: assert property (p_nmi_hold) else $error("nmi exit");
endmodule // fault_checker

bind cpu_fault_handling_unit fault_checker #(.PRIO_W(PRIO_W)) chk_u (.sys_clk, .reset_n, .report, .access_addr,
    .data_addr, .context_in, .usage_priority, .handler_enable_reg, .nmi_request, .debug_halt, .hard_fault_cause_reg,
    .memmanage_fault_cause_reg, .bus_fault_cause_reg, .memmanage_fault_address, .bus_fault_address,
    .fault_handler, .fault_priority, .hard_priority_fixed, .hard_preempts, .escalated, .lockup, .lockup_from_nmi);

//--- tb/cpu_fault_handling_unit_test.sv
`timescale 1ns/100ps
`include "fault_defs.svh"

module cpu_fault_handling_unit_test;
    localparam fault_pkg::exc_kind_e KH = fault_pkg::KIND_HARD;
    localparam fault_pkg::exc_kind_e KM = fault_pkg::KIND_MEM;
    localparam fault_pkg::exc_kind_e KB = fault_pkg::KIND_BUS;
    localparam fault_pkg::exc_kind_e KU = fault_pkg::KIND_USAGE;
    logic sys_clk, reset_n, cmd_valid, nmi_request, debug_halt, clr;
    logic fault_taken, hard_priority_fixed, hard_preempts, escalated, lockup, lockup_from_nmi;
    logic memmanage_address_valid, bus_address_valid;
    logic [17:0] cmd_bits;
    logic [31:0] cmd_addr, access_addr, data_addr, memmanage_fault_address, bus_fault_address;
    logic [2:0] current_priority, mm_priority, bus_priority, usage_priority, fault_priority, handler_enable_reg;
    logic [1:0] hard_fault_cause_reg;
    logic [3:0] memmanage_fault_cause_reg;
    logic [4:0] bus_fault_cause_reg;
    logic [5:0] usage_fault_cause_reg;
    logic [16:0] flags;
    fault_pkg::fault_report_s report;
    fault_pkg::exec_context_s context_in;
    fault_pkg::exc_kind_e fault_handler;
    int error_cnt = 0;
    int n_compared = 0;

    assign flags = {hard_fault_cause_reg, memmanage_fault_cause_reg, bus_fault_cause_reg, usage_fault_cause_reg};

    fault_source src_u (.sys_clk, .cmd_valid, .cmd_bits, .cmd_addr, .report, .access_addr, .data_addr);

    cpu_fault_handling_unit #(.PRIO_W(3)) dut_u (.sys_clk, .reset_n, .report, .access_addr, .data_addr, .context_in,
        .current_priority, .mm_priority, .bus_priority, .usage_priority, .handler_enable_reg, .nmi_request,
        .debug_halt, .hard_clear({2{clr}}), .mm_clear({4{clr}}), .bus_clear({5{clr}}), .usage_clear({6{clr}}),
        .mm_addr_clear(clr), .bus_addr_clear(clr), .hard_fault_cause_reg, .memmanage_fault_cause_reg,
        .bus_fault_cause_reg, .usage_fault_cause_reg, .memmanage_fault_address, .memmanage_address_valid,
        .bus_fault_address, .bus_address_valid, .fault_taken, .fault_handler, .fault_priority,
        .hard_priority_fixed, .hard_preempts, .escalated, .lockup, .lockup_from_nmi);

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic check_vec(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_kind(input fault_pkg::exc_kind_e got, input fault_pkg::exc_kind_e exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic setup(input fault_pkg::exec_context_s c, input logic [2:0] p, input logic [2:0] e);
        @(posedge sys_clk);
        context_in <= c;
        current_priority <= p;
        handler_enable_reg <= e;
    endtask

    task automatic fire(input logic [17:0] bits, input logic [31:0] a);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_bits <= bits;
        cmd_addr <= a;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic pulse(input logic n, input logic d);
        @(posedge sys_clk);
        nmi_request <= n;
        debug_halt <= d;
        @(posedge sys_clk);
        nmi_request <= 1'b0;
        debug_halt <= 1'b0;
        #1;
    endtask

    task automatic clear;
        @(posedge sys_clk);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        #1;
        check_vec(flags, 17'h0);
    endtask

    // ak: 0 none, 1 fetch, 2 data, 3 bus address
    task automatic one(input logic [17:0] bits, input logic [16:0] exp, input fault_pkg::exc_kind_e kind, input int ak);
        logic [31:0] a;
        a = 32'hC0DE_0000 | 32'(bits);
        fire(bits, a);
        check_vec(flags, exp);
        check_vec(fault_taken, 1'b1);
        check_kind(fault_handler, kind);
        check_vec(fault_priority, kind == KM ? 3'h1 : kind == KB ? 3'h2 : kind == KU ? 3'h5 : 3'h0);
        check_vec(escalated, exp[16]);
        check_vec({hard_priority_fixed, hard_preempts}, {2{kind == KH}});
        if (ak != 0)
            check_vec(ak == 3 ? bus_fault_address : memmanage_fault_address, ak == 1 ? a : {a[15:0], a[31:16]});
        check_vec({memmanage_address_valid, bus_address_valid}, {ak == 1 || ak == 2, ak == 3});
        @(posedge sys_clk);
        #1;
        check_vec(flags, exp);
        clear;
    endtask

    initial
    begin
        repeat (3000) @(posedge sys_clk);
        error_cnt++;
        end_sim;
    end

    initial
    begin
        reset_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_bits = '0;
        cmd_addr = 32'h0;
        nmi_request = 1'b0;
        debug_halt = 1'b0;
        clr = 1'b0;
        context_in = '0;
        current_priority = 3'h7;
        mm_priority = 3'h1;
        bus_priority = 3'h2;
        usage_priority = 3'h5;
        handler_enable_reg = 3'h7;
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        one(18'h20000, 17'h00800, KM, 1);
        one(18'h10000, 17'h00800, KM, 1);
        one(18'h08000, 17'h01000, KM, 2);
        one(18'h04000, 17'h02000, KM, 0);
        one(18'h02000, 17'h04000, KM, 0);
        one(18'h01000, 17'h08000, KH, 0);
        one(18'h00800, 17'h00400, KB, 0);
        one(18'h00400, 17'h00200, KB, 0);
        one(18'h00200, 17'h00040, KB, 0);
        one(18'h00180, 17'h00080, KB, 3);
        one(18'h00100, 17'h00100, KB, 0);
        one(18'h00040, 17'h00008, KU, 0);
        one(18'h00020, 17'h00001, KU, 0);
        one(18'h00010, 17'h00002, KU, 0);
        one(18'h00008, 17'h00002, KU, 0);
        one(18'h00004, 17'h00004, KU, 0);
        one(18'h00002, 17'h00010, KU, 0);
        one(18'h00001, 17'h00020, KU, 0);
        setup('0, 3'h7, 3'h3);
        one(18'h00002, 17'h10010, KH, 0);
        setup({1'b1, KU, 1'b0}, 3'h7, 3'h7);
        one(18'h00001, 17'h10020, KH, 0);
        setup({1'b1, fault_pkg::KIND_OTHER, 1'b0}, 3'h5, 3'h7);
        one(18'h00020, 17'h10001, KH, 0);
        setup({1'b1, fault_pkg::KIND_OTHER, 1'b0}, 3'h6, 3'h7);
        one(18'h00020, 17'h00001, KU, 0);
        setup({1'b1, KB, 1'b1}, 3'h2, 3'h7);
        one(18'h00800, 17'h00400, KB, 0);
        setup({1'b1, KH, 1'b0}, 3'h0, 3'h7);
        fire(18'h01000, 32'h0);
        check_vec({lockup, lockup_from_nmi, hard_preempts}, 3'b100);
        fire(18'h00002, 32'h0);
        check_vec({fault_taken, usage_fault_cause_reg}, 7'h10);
        pulse(1'b1, 1'b0);
        check_vec(lockup, 1'b0);
        clear;
        setup({1'b1, fault_pkg::KIND_NMI, 1'b0}, 3'h0, 3'h7);
        fire(18'h01000, 32'h0);
        check_vec({lockup, lockup_from_nmi}, 2'b11);
        pulse(1'b1, 1'b0);
        check_vec(lockup, 1'b1);
        pulse(1'b0, 1'b1);
        check_vec(lockup, 1'b0);
        clear;
        end_sim;
    end
endmodule // cpu_fault_handling_unit_test
